// [logic/txpt_top.v]
// Overview of operation
// [RULE_01] A six-bit scale code per channel, reset to 100001, scales the amplitude of the programmed pulse.
// [RULE_02] For T1 short haul, J1 and DS1 0 dB the nominal code is 110110 and each code step is 2 percent.
// [RULE_03] For DS1 at -7.5 dB the nominal code is 010001 and each code step is 6.25 percent.
// [RULE_04] For DS1 at -15 dB the nominal code is 001000 and each code step is 12.5 percent.
// [RULE_05] For DS1 at -22.5 dB the nominal code is 000100 and each code step is 25 percent.
// [RULE_06] For E1 on 75 or 120 ohm cable the nominal code is 100001 and each code step is 3 percent.
// [RULE_07] Writing one to bit 7 of the access control register starts one template RAM access.
// [RULE_08] Bit 6 of access control picks the direction, 0 writes the RAM and 1 reads it.
// [RULE_09] Bits 5-4 of access control pick one of four unit intervals, 00 being the leftmost.
// [RULE_10] Bits 3-0 of access control pick one of sixteen samples, 0000 being the leftmost.
// [RULE_11] An indirect write stores the seven-bit data field as the addressed sample amplitude.
// [RULE_12] A completed indirect read puts the stored amplitude into the seven-bit data field.
// [RULE_13] Each of eight channels has its own register set, windows 0x20 apart starting at 0x04.
// [RULE_14] The access uses the field values present at the moment the trigger is written.
`timescale 1ns/1ps
`default_nettype none
`include "txpt_regs.vh"

module txpt_top #(
  parameter NCH = 8
) (
  // Clock and reset.
  input  wire              clk_i,
  input  wire              rst_n_i,
  // AHB-Lite slave.
  input  wire              hsel_i,
  input  wire [31:0]       haddr_i,
  input  wire [1:0]        htrans_i,
  input  wire              hwrite_i,
  input  wire [2:0]        hsize_i,
  input  wire [31:0]       hwdata_i,
  input  wire              hready_i,
  output reg  [31:0]       hrdata_o,
  output reg               hreadyout_o,
  output reg               hresp_o,
  // Waveform shaper fetch port.
  input  wire              shp_req_i,
  input  wire [2:0]        shp_ch_i,
  input  wire [5:0]        shp_addr_i,
  output wire [6:0]        shp_amp_o,
  output wire              shp_amp_valid_o,
  // Per-channel scale codes, channel 0 in the low bits.
  output reg  [6*NCH-1:0]  amplitude_scale_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  reg [5:0] scale_q   [0:NCH-1];
  reg [7:0] access_q  [0:NCH-1];
  reg [6:0] data_q    [0:NCH-1];
  reg [2:0] profile_q [0:NCH-1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus data phase tracking.

  reg       dp_q;
  reg       dp_wr_q;
  reg       dp_word_q;
  reg [7:0] dp_idx_q;

  // Indirect access engine.
  reg       req_q;
  reg       req_rd_q;
  reg [2:0] req_ch_q;
  reg [5:0] req_addr_q;
  reg [6:0] req_wd_q;
  reg       fin_q;

  wire       busy   = req_q | fin_q;
  wire       accept = hsel_i & htrans_i[1] & hready_i;
  // The data phase always carries one wait state and holds off while an access runs.
  wire       commit = dp_q & ~hreadyout_o & ~busy;
  wire [2:0] dp_ch  = dp_idx_q[7:5]; // [RULE_13]
  wire [4:0] dp_off = dp_idx_q[4:0];
  wire       wr_go  = commit & dp_wr_q & dp_word_q;
  wire [6:0] ram_a_rdata;

  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux.

  reg [31:0] rd_val;

  always @* begin
    rd_val = 32'h00000000;
    if (dp_off == `TXPT_IDX_SCALE) begin
      rd_val = {26'h0, scale_q[dp_ch]};
    end else if (dp_off == `TXPT_IDX_ACCESS) begin
      rd_val = {24'h0, access_q[dp_ch]};
    end else if (dp_off == `TXPT_IDX_DATA) begin
      rd_val = {25'h0, data_q[dp_ch]};
    end else if (dp_off == `TXPT_IDX_PROFILE) begin
      rd_val = {29'h0, profile_q[dp_ch]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_q        <= 1'b0;
      dp_wr_q     <= 1'b0;
      dp_word_q   <= 1'b0;
      dp_idx_q    <= 8'h00;
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (commit) begin
        dp_q        <= 1'b0;
        hreadyout_o <= 1'b1;
        if (!dp_wr_q) begin
          hrdata_o <= rd_val;
        end
      end
      if (accept) begin
        dp_q        <= 1'b1;
        dp_wr_q     <= hwrite_i;
        dp_word_q   <= (hsize_i == 3'h2);
        dp_idx_q    <= haddr_i[9:2]; // [RULE_13]
        hreadyout_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and access completion.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < NCH; i = i + 1) begin
        scale_q[i]   <= `TXPT_RST_SCALE; // [RULE_01]
        access_q[i]  <= `TXPT_RST_ACCESS;
        data_q[i]    <= `TXPT_RST_DATA;
        profile_q[i] <= `TXPT_RST_PROFILE;
      end
    end else begin
      // A write commit never lands on the completion cycle, since commit waits for idle.
      if (wr_go) begin
        if (dp_off == `TXPT_IDX_SCALE) begin
          scale_q[dp_ch] <= hwdata_i[5:0]; // [RULE_01]
        end else if (dp_off == `TXPT_IDX_ACCESS) begin
          access_q[dp_ch] <= hwdata_i[7:0]; // [RULE_07]
        end else if (dp_off == `TXPT_IDX_DATA) begin
          data_q[dp_ch] <= hwdata_i[6:0];
        end else if (dp_off == `TXPT_IDX_PROFILE) begin
          profile_q[dp_ch] <= hwdata_i[2:0];
        end
      end
      if (fin_q) begin
        access_q[req_ch_q][`TXPT_ACC_TRIG_BIT] <= 1'b0; // [RULE_07]
        if (req_rd_q) begin
          data_q[req_ch_q] <= ram_a_rdata; // [RULE_12]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect access engine.

  wire trig = wr_go & (dp_off == `TXPT_IDX_ACCESS) & hwdata_i[`TXPT_ACC_TRIG_BIT];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q      <= 1'b0;
      req_rd_q   <= 1'b0;
      req_ch_q   <= 3'h0;
      req_addr_q <= 6'h00;
      req_wd_q   <= 7'h00;
      fin_q      <= 1'b0;
    end else begin
      fin_q <= req_q;
      if (trig) begin
        req_q      <= 1'b1; // [RULE_07]
        req_ch_q   <= dp_ch;
        // Fields are frozen from the trigger write itself.
        req_rd_q   <= hwdata_i[`TXPT_ACC_DIR_BIT]; // [RULE_14] [RULE_08]
        req_addr_q <= {hwdata_i[`TXPT_ACC_UI_MSB:`TXPT_ACC_UI_LSB],
                       hwdata_i[`TXPT_ACC_PT_MSB:`TXPT_ACC_PT_LSB]}; // [RULE_09] [RULE_10]
        req_wd_q   <= data_q[dp_ch]; // [RULE_14]
      end else begin
        req_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Template memory and shaper path.

  reg [2:0] b_ch_q;
  reg       b_vld_q;
  wire [6:0] b_rdata;

  txpt_ram #(
    .AW (9),
    .DW (7)
  ) u_ram (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .a_en_i    (req_q),
    .a_we_i    (~req_rd_q), // [RULE_08]
    .a_addr_i  ({req_ch_q, req_addr_q}), // [RULE_09] [RULE_10]
    .a_wdata_i (req_wd_q), // [RULE_11]
    .a_rdata_o (ram_a_rdata),
    .b_en_i    (shp_req_i),
    .b_addr_i  ({shp_ch_i, shp_addr_i}),
    .b_rdata_o (b_rdata)
  );

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      b_ch_q  <= 3'h0;
      b_vld_q <= 1'b0;
    end else begin
      b_vld_q <= shp_req_i;
      if (shp_req_i) begin
        b_ch_q <= shp_ch_i;
      end
    end
  end

  // Scale and profile are taken at the RAM output, so a change mid-pulse applies per sample.
  txpt_scale u_scale (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .en_i      (b_vld_q),
    .sample_i  (b_rdata),
    .scale_i   (scale_q[b_ch_q]), // [RULE_01]
    .profile_i (profile_q[b_ch_q]),
    .amp_o     (shp_amp_o),
    .valid_o   (shp_amp_valid_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Scale code fan-out.

  // One flop group per channel, so the register loop variable has a single owner.
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_fan
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          amplitude_scale_o[6*g +: 6] <= `TXPT_RST_SCALE;
        end else begin
          amplitude_scale_o[6*g +: 6] <= scale_q[g]; // [RULE_13]
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [logic/txpt_regs.vh]
`ifndef TXPT_REGS_VH
`define TXPT_REGS_VH

// Register indices within one channel window; byte address is four times the index.
`define TXPT_IDX_SCALE        5'h04
`define TXPT_IDX_ACCESS       5'h05
`define TXPT_IDX_DATA         5'h06
`define TXPT_IDX_PROFILE      5'h1c
// Channel windows are spaced this many register indices apart.
`define TXPT_CH_STRIDE        8'h20

// Reset values.
`define TXPT_RST_SCALE        6'h21
`define TXPT_RST_ACCESS       8'h00
`define TXPT_RST_DATA         7'h00
`define TXPT_RST_PROFILE      3'h4

// Access control field positions.
`define TXPT_ACC_TRIG_BIT     7
`define TXPT_ACC_DIR_BIT      6
`define TXPT_ACC_UI_MSB       5
`define TXPT_ACC_UI_LSB       4
`define TXPT_ACC_PT_MSB       3
`define TXPT_ACC_PT_LSB       0

// Line profiles selecting nominal code and step size.
`define TXPT_PROF_T1_SH       3'h0
`define TXPT_PROF_DS1_7P5     3'h1
`define TXPT_PROF_DS1_15      3'h2
`define TXPT_PROF_DS1_22P5    3'h3
`define TXPT_PROF_E1          3'h4

// Nominal scale codes.
`define TXPT_NOM_T1_SH        6'h36
`define TXPT_NOM_DS1_7P5      6'h11
`define TXPT_NOM_DS1_15       6'h08
`define TXPT_NOM_DS1_22P5     6'h04
`define TXPT_NOM_E1           6'h21

// Step sizes in hundredths of a percent, and unity gain in the same unit.
`define TXPT_STEP_T1_SH       12'h0c8
`define TXPT_STEP_DS1_7P5     12'h271
`define TXPT_STEP_DS1_15      12'h4e2
`define TXPT_STEP_DS1_22P5    12'h9c4
`define TXPT_STEP_E1          12'h12c
`define TXPT_GAIN_UNITY       22'h002710
// Reciprocal of unity gain as a multiply and a shift.
`define TXPT_RECIP_MUL        13'h1a37
`define TXPT_RECIP_SHIFT      26

`endif

// [logic/txpt_ram.v]
`timescale 1ns/1ps
`default_nettype none

module txpt_ram #(
  parameter AW = 9,
  parameter DW = 7
) (
  // Clock and reset.
  input  wire          clk_i,
  input  wire          rst_n_i,
  // Port A: indirect register access.
  input  wire          a_en_i,
  input  wire          a_we_i,
  input  wire [AW-1:0] a_addr_i,
  input  wire [DW-1:0] a_wdata_i,
  output reg  [DW-1:0] a_rdata_o,
  // Port B: waveform shaper fetch.
  input  wire          b_en_i,
  input  wire [AW-1:0] b_addr_i,
  output reg  [DW-1:0] b_rdata_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // The array itself has no reset; software loads a template before use.
  always @(posedge clk_i) begin
    if (a_en_i && a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_rdata_o <= {DW{1'b0}};
      b_rdata_o <= {DW{1'b0}};
    end else begin
      if (a_en_i && !a_we_i) begin
        a_rdata_o <= mem[a_addr_i];
      end
      if (b_en_i) begin
        b_rdata_o <= mem[b_addr_i];
      end
    end
  end

endmodule

`default_nettype wire

// [logic/txpt_scale.v]
`timescale 1ns/1ps
`default_nettype none
`include "txpt_regs.vh"

module txpt_scale (
  // Clock and reset.
  input  wire       clk_i,
  input  wire       rst_n_i,
  // Sample in.
  input  wire       en_i,
  input  wire [6:0] sample_i,
  input  wire [5:0] scale_i,
  input  wire [2:0] profile_i,
  // Scaled sample out.
  output reg  [6:0] amp_o,
  output reg        valid_o
);

  reg [5:0]  nom;
  reg [11:0] step;

  always @* begin
    case (profile_i)
      `TXPT_PROF_T1_SH: begin
        nom  = `TXPT_NOM_T1_SH; // [RULE_02]
        step = `TXPT_STEP_T1_SH;
      end
      `TXPT_PROF_DS1_7P5: begin
        nom  = `TXPT_NOM_DS1_7P5; // [RULE_03]
        step = `TXPT_STEP_DS1_7P5;
      end
      `TXPT_PROF_DS1_15: begin
        nom  = `TXPT_NOM_DS1_15; // [RULE_04]
        step = `TXPT_STEP_DS1_15;
      end
      `TXPT_PROF_DS1_22P5: begin
        nom  = `TXPT_NOM_DS1_22P5; // [RULE_05]
        step = `TXPT_STEP_DS1_22P5;
      end
      default: begin
        nom  = `TXPT_NOM_E1; // [RULE_06]
        step = `TXPT_STEP_E1;
      end
    endcase
  end

  // Gain is unity at the nominal code and moves one step per code.
  wire signed [7:0]  diff   = $signed({2'b00, scale_i}) - $signed({2'b00, nom});
  wire signed [21:0] gain   = $signed(`TXPT_GAIN_UNITY) + diff * $signed({1'b0, step}); // [RULE_01]
  wire        [17:0] gain_u = gain[21] ? 18'h00000 : gain[17:0];
  wire        [24:0] prod   = sample_i * gain_u;
  // Dividing by unity through a reciprocal keeps a divider out of the path.
  wire        [37:0] prod_r = prod * `TXPT_RECIP_MUL;
  wire        [11:0] quot   = prod_r[37:`TXPT_RECIP_SHIFT];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      amp_o   <= 7'h00;
      valid_o <= 1'b0;
    end else begin
      valid_o <= en_i;
      if (en_i) begin
        // Saturate rather than wrap so an oversized scale clips the peak.
        amp_o <= (quot > 12'h07f) ? 7'h7f : quot[6:0]; // [RULE_01]
      end
    end
  end

endmodule

`default_nettype wire

// [verification/txpt_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module txpt_checker #(
  parameter NCH = 8
) (
  // Clock and reset.
  input wire             clk_i,
  input wire             rst_n_i,
  // Bus side.
  input wire             hsel_i,
  input wire [1:0]       htrans_i,
  input wire             hready_i,
  input wire [31:0]      hrdata_o,
  input wire             hreadyout_o,
  input wire             hresp_o,
  // Shaper side.
  input wire             shp_req_i,
  input wire             shp_amp_valid_o,
  input wire [6*NCH-1:0] amplitude_scale_o
);
  wire acc = hsel_i & htrans_i[1] & hready_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  wait_state_a: assert property (acc |=> !hreadyout_o)
    else $error("accepted transfer without wait state");
  wait_bound_a: assert property (acc |=> ##[1:3] hreadyout_o)
    else $error("data phase longer than four cycles");
  ready_idle_a: assert property (hreadyout_o && !acc |=> hreadyout_o)
    else $error("ready dropped without a transfer");
  rdata_hold_a: assert property (!$stable(hrdata_o) |-> $rose(hreadyout_o))
    else $error("read data changed outside a commit");
  scale_commit_a: assert property (!$stable(amplitude_scale_o) |->
    $past(hreadyout_o) && !$past(hreadyout_o, 2))
    else $error("scale output changed without a write commit");
  shp_lat_a: assert property (shp_req_i |-> ##2 shp_amp_valid_o)
    else $error("shaper answer missing two cycles after request");
  shp_only_a: assert property (shp_amp_valid_o |-> $past(shp_req_i, 2))
    else $error("shaper answer without request");
endmodule

bind txpt_top txpt_checker #(.NCH(NCH)) txpt_checker_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .shp_req_i(shp_req_i), .shp_amp_valid_o(shp_amp_valid_o),
  .amplitude_scale_o(amplitude_scale_o));

`default_nettype wire

// [verification/txpt_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module txpt_top_tb;
  reg         clk_i, rst_n_i, hsel_i, hwrite_i, shp_req_i;
  reg  [31:0] haddr_i, hwdata_i, rd_v;
  reg  [1:0]  htrans_i;
  reg  [2:0]  hsize_i, shp_ch_i;
  reg  [5:0]  shp_addr_i;
  wire [31:0] hrdata_o;
  wire        hreadyout_o, hresp_o, shp_amp_valid_o;
  wire [6:0]  shp_amp_o;
  wire [47:0] amplitude_scale_o;
  integer     n_mismatch = 0, n_tests = 0, i, p;
  integer     stp [0:4] = '{200, 625, 1250, 2500, 300};
  reg  [5:0]  nom [0:4] = '{6'h36, 6'h11, 6'h08, 6'h04, 6'h21};
  // Row: channel, index, write value, value read back.
  reg  [23:0] rows [0:5] = '{{3'h0, 5'h04, 8'hff, 8'h3f}, {3'h7, 5'h04, 8'h36, 8'h36},
    {3'h3, 5'h06, 8'hff, 8'h7f}, {3'h5, 5'h1c, 8'hfb, 8'h03},
    {3'h2, 5'h00, 8'hff, 8'h00}, {3'h1, 5'h1f, 8'h5a, 8'h00}};

  txpt_top txpt_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .shp_req_i(shp_req_i), .shp_ch_i(shp_ch_i), .shp_addr_i(shp_addr_i), .shp_amp_o(shp_amp_o),
    .shp_amp_valid_o(shp_amp_valid_o), .amplitude_scale_o(amplitude_scale_o));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  function [31:0] ad(input [2:0] ch, input [4:0] idx);
    ad = {22'h0, ch, idx, 2'b00};
  endfunction

  // Expected amplitude, clamped at both ends like the line driver range.
  function [6:0] amp(input [6:0] s, input integer g);
    longint v;
    begin
      v = (g < 0) ? 0 : g;
      v = (v * s * 6711) >>> 26;
      amp = (v > 127) ? 7'h7f : v[6:0];
    end
  endfunction

  task chk(input [47:0] g, input [47:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  // One single transfer; the address phase is held until ready is seen high.
  task bus(input [31:0] a, input w, input [2:0] sz, input [31:0] d);
    begin
      haddr_i <= a;
      hwrite_i <= w;
      hsize_i <= sz;
      htrans_i <= 2'h2;
      hsel_i <= 1'b1;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd_v = hrdata_o;
    end
  endtask

  task rdc(input [31:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 3'h2, 32'h0);
      chk(rd_v, e);
    end
  endtask

  task shp(input [2:0] ch, input [5:0] a, input [6:0] e);
    begin
      shp_req_i <= 1'b1;
      shp_ch_i <= ch;
      shp_addr_i <= a;
      @(posedge clk_i);
      shp_req_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk({shp_amp_valid_o, shp_amp_o}, {1'b1, e});
      @(posedge clk_i);
    end
  endtask

  task test_done;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end

  initial begin
    {rst_n_i, hsel_i, hwrite_i, shp_req_i, htrans_i, hsize_i, shp_ch_i, shp_addr_i} = 0;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk(amplitude_scale_o, {8{6'h21}});
    for (i = 0; i < 8; i = i + 7) begin
      rdc(ad(i[2:0], 5'h04), 32'h21);
      rdc(ad(i[2:0], 5'h05), 32'h00);
      rdc(ad(i[2:0], 5'h06), 32'h00);
      rdc(ad(i[2:0], 5'h1c), 32'h04);
    end
    for (i = 0; i < 6; i = i + 1) begin
      bus(ad(rows[i][23:21], rows[i][20:16]), 1'b1, 3'h2, {24'h0, rows[i][15:8]});
      rdc(ad(rows[i][23:21], rows[i][20:16]), {24'h0, rows[i][7:0]});
    end
    chk(amplitude_scale_o, {6'h36, {6{6'h21}}, 6'h3f});
    // A byte write must not disturb the word-wide register.
    bus(ad(3'h0, 5'h04), 1'b1, 3'h0, 32'h11);
    rdc(ad(3'h0, 5'h04), 32'h3f);
    for (i = 0; i < 4; i = i + 1) begin
      p = i * 5;
      bus(ad(3'h2, 5'h06), 1'b1, 3'h2, 32'h7f - i * 32'h11);
      bus(ad(3'h2, 5'h05), 1'b1, 3'h2, {24'h0, 2'b10, i[1:0], p[3:0]});
    end
    for (i = 0; i < 4; i = i + 1) begin
      p = i * 5;
      bus(ad(3'h2, 5'h06), 1'b1, 3'h2, 32'h0);
      bus(ad(3'h2, 5'h05), 1'b1, 3'h2, {24'h0, 2'b11, i[1:0], p[3:0]});
      rdc(ad(3'h2, 5'h06), 32'h7f - i * 32'h11);
      bus(ad(3'h2, 5'h05), 1'b0, 3'h2, 32'h0);
      chk(rd_v & 32'h80, 32'h0);
    end
    for (i = 0; i < 5; i = i + 1) begin
      bus(ad(3'h2, 5'h1c), 1'b1, 3'h2, i);
      bus(ad(3'h2, 5'h04), 1'b1, 3'h2, {26'h0, nom[i]});
      shp(3'h2, 6'h15, amp(7'h6e, 10000));
      bus(ad(3'h2, 5'h04), 1'b1, 3'h2, {26'h0, nom[i]} + 32'h1);
      shp(3'h2, 6'h15, amp(7'h6e, 10000 + stp[i]));
    end
    bus(ad(3'h2, 5'h04), 1'b1, 3'h2, 32'h3f);
    shp(3'h2, 6'h15, amp(7'h6e, 19000));
    bus(ad(3'h2, 5'h1c), 1'b1, 3'h2, 32'h0);
    bus(ad(3'h2, 5'h04), 1'b1, 3'h2, 32'h0);
    shp(3'h2, 6'h15, 7'h00);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(amplitude_scale_o, {8{6'h21}});
    rdc(ad(3'h2, 5'h04), 32'h21);
    test_done;
  end
endmodule

`default_nettype wire
